// ### hw/sgan_regs.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module sgan_regs import sgan_pkg::*; #(
  parameter int HOLD_WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // mode and link state
  input wire logic mac_side,
  input wire logic sgmii_mode,
  input wire logic lock_in,
  input wire logic link_up_in,
  input wire logic full_duplex_in,
  input wire logic [1:0] speed_in,
  // auto-negotiation engine
  input wire logic an_complete_in,
  input wire logic an_error_in,
  input wire logic page_valid,
  input wire logic [15:0] page_word,
  input wire logic np_valid,
  input wire logic [15:0] np_word,
  output logic [15:0] adv_word_out,
  output logic [15:0] np_tx_out,
  output logic np_loaded_out,
  // resolved link
  output logic [1:0] res_speed,
  output logic res_duplex,
  // diagnostic sources
  input wire logic [HOLD_WIDTH-1:0] diag_hold_in,
  input wire logic [15:0] diag_sync_in,
  input wire logic [15:0] diag_an_in,
  input wire logic [15:0] diag_ordered_set_transmitter_in,
  input wire logic [15:0] diag_code_group_transmitter_in,
  input wire logic [31:0] diag_rx_in,
  // interrupt
  output logic irq
);
  logic [15:0] adv_reg;
  logic [15:0] adv_next;
  logic [15:0] np_tx_reg;
  logic [15:0] lp_adv_reg;
  logic [15:0] np_rx_reg;
  logic master_reg;
  logic np_loaded_reg;
  logic page_rx_reg;
  logic np_seen_reg;
  logic an_done_reg;
  sgan_src_type src_reg;
  sgan_cap_type cap_reg;
  sgan_flush_type flush_state_reg;
  logic [1:0] flush_cnt_reg;
  logic flush_req_reg;
  logic flush_s1_reg;
  logic flush_s2_reg;
  logic flush_pulse;
  logic [HOLD_WIDTH-1:0] hold_s1_reg;
  logic [HOLD_WIDTH-1:0] hold_s2_reg;
  logic [HOLD_WIDTH-1:0] hold_view;
  logic [15:0] diag_view;
  logic [15:0] diag_reg;
  logic [SGAN_INT_BITS-1:0] int_stat_reg;
  logic [SGAN_INT_BITS-1:0] int_en_reg;
  logic [SGAN_INT_BITS-1:0] int_evt;
  logic lock_s1_reg;
  logic lock_reg;
  logic [31:0] rdata_next;
  logic page_evt;
  logic np_evt;
  logic np_load_wr;

  initial begin
    if (HOLD_WIDTH < 1 || HOLD_WIDTH > 16) $error("sgan_regs: HOLD_WIDTH must be 1..16");
  end

  assign np_load_wr = reg_wr && reg_addr == SGAN_OFF_CONTROL && reg_wdata[SGAN_CTL_NP_LOADED];

  // lock comes from the serdes, so resynchronise it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_s1_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      lock_s1_reg <= lock_in;
      lock_reg <= lock_s1_reg;
    end
  end

  assign page_evt = page_valid && lock_reg;
  assign np_evt = np_valid && lock_reg && !sgmii_mode;

  // local ability word: mac fields come from live link state
  always_comb begin
    adv_next = SGAN_PHY_ADV;
    if (mac_side) begin
      adv_next[SGAN_ADV_LINK] = link_up_in;
      adv_next[SGAN_ADV_DUPLEX] = full_duplex_in;
      adv_next[SGAN_ADV_SPD_HI:SGAN_ADV_SPD_LO] = speed_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) adv_reg <= SGAN_PHY_ADV;
    else adv_reg <= adv_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      np_tx_reg <= '0;
      master_reg <= 1'b0;
    end else if (reg_wr && reg_addr == SGAN_OFF_NP_TX) begin
      np_tx_reg <= reg_wdata[15:0];
    end else if (reg_wr && reg_addr == SGAN_OFF_CONTROL) begin
      master_reg <= reg_wdata[SGAN_CTL_MASTER];
    end
  end

  // captured partner words hold until the next page
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lp_adv_reg <= '0;
      np_rx_reg <= '0;
    end else begin
      if (page_evt) lp_adv_reg <= page_word;
      if (np_evt) np_rx_reg <= np_word;
    end
  end

  // np loaded drops the cycle the page arrives; page flag rises a cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_n) np_loaded_reg <= 1'b0;
    else if (np_evt) np_loaded_reg <= 1'b0;
    else if (np_load_wr && !sgmii_mode) np_loaded_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      np_seen_reg <= 1'b0;
      page_rx_reg <= 1'b0;
    end else begin
      np_seen_reg <= np_evt;
      if (np_seen_reg) page_rx_reg <= 1'b1;
      else if (np_load_wr) page_rx_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) an_done_reg <= 1'b0;
    else an_done_reg <= an_complete_in && lock_reg;
  end

  // master mode takes speed and duplex from the local word
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      res_speed <= '0;
      res_duplex <= 1'b0;
    end else if (master_reg) begin
      res_speed <= adv_reg[SGAN_ADV_SPD_HI:SGAN_ADV_SPD_LO];
      res_duplex <= adv_reg[SGAN_ADV_DUPLEX];
    end else if (an_done_reg) begin
      res_speed <= lp_adv_reg[SGAN_ADV_SPD_HI:SGAN_ADV_SPD_LO];
      res_duplex <= lp_adv_reg[SGAN_ADV_DUPLEX];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adv_word_out <= SGAN_PHY_ADV;
      np_tx_out <= '0;
      np_loaded_out <= 1'b0;
    end else begin
      adv_word_out <= adv_reg;
      np_tx_out <= np_tx_reg;
      np_loaded_out <= np_loaded_reg;
    end
  end

  // diagnostic control
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_reg <= sgan_src_type'(SGAN_DIAG_CTL_RST[SGAN_DIAG_SRC_HI:SGAN_DIAG_SRC_LO]);
      cap_reg <= sgan_cap_type'(SGAN_DIAG_CTL_RST[1:0]);
    end else if (reg_wr && reg_addr == SGAN_OFF_DIAG_CTL) begin
      src_reg <= sgan_src_type'(reg_wdata[SGAN_DIAG_SRC_HI:SGAN_DIAG_SRC_LO]);
      cap_reg <= sgan_cap_type'(reg_wdata[1:0]);
    end
  end

  // flush request passes a synchroniser pair before it clears anything
  always_ff @(posedge sys_clk) begin
    if (!rst_n) flush_req_reg <= 1'b0;
    else if (reg_wr && reg_addr == SGAN_OFF_DIAG_CLR && reg_wdata[SGAN_DIAG_CLR_BIT]) flush_req_reg <= 1'b1;
    // drop once it has crossed, so one write flushes only once
    else if (flush_s2_reg) flush_req_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flush_s1_reg <= 1'b0;
      flush_s2_reg <= 1'b0;
    end else begin
      flush_s1_reg <= flush_req_reg;
      flush_s2_reg <= flush_s1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flush_state_reg <= SGAN_FL_IDLE;
      flush_cnt_reg <= '0;
    end else begin
      case (flush_state_reg)
        SGAN_FL_IDLE: begin
          if (flush_s2_reg) begin
            flush_state_reg <= SGAN_FL_SYNC;
            flush_cnt_reg <= '0;
          end
        end
        SGAN_FL_SYNC: begin
          flush_cnt_reg <= flush_cnt_reg + 2'h1;
          if (flush_cnt_reg == 2'(SGAN_FLUSH_SYNC - 1)) flush_state_reg <= SGAN_FL_CLEAR;
        end
        SGAN_FL_CLEAR: flush_state_reg <= SGAN_FL_IDLE;
        default: flush_state_reg <= SGAN_FL_IDLE;
      endcase
    end
  end

  assign flush_pulse = flush_state_reg == SGAN_FL_CLEAR;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_s1_reg <= '0;
      hold_s2_reg <= '0;
    end else begin
      hold_s1_reg <= diag_hold_in;
      hold_s2_reg <= hold_s1_reg;
    end
  end

  sgan_hold_capture #(.WIDTH(HOLD_WIDTH)) u_hold (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .capture_mode(cap_reg),
    .clear(flush_pulse),
    .hold_in(hold_s2_reg),
    .hold_out(hold_view)
  );

  always_comb begin
    case (src_reg)
      SGAN_SRC_HOLD: diag_view = 16'(hold_view);
      SGAN_SRC_SYNC: diag_view = diag_sync_in;
      SGAN_SRC_AN: diag_view = diag_an_in;
      SGAN_SRC_ORDERED_SET_TRANSMITTER: diag_view = diag_ordered_set_transmitter_in;
      SGAN_SRC_CODE_GROUP_TRANSMITTER: diag_view = diag_code_group_transmitter_in;
      SGAN_SRC_RXLO: diag_view = diag_rx_in[15:0];
      SGAN_SRC_RXHI: diag_view = diag_rx_in[31:16];
      default: diag_view = 16'h0000;
    endcase
  end

  // status persists across a flush only if its source is still set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) diag_reg <= '0;
    else if (flush_pulse) diag_reg <= '0;
    else diag_reg <= diag_view;
  end

  // interrupts: set wins over clear
  assign int_evt = {an_error_in && lock_reg, an_complete_in && lock_reg && !an_done_reg, np_evt};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) int_stat_reg <= '0;
    else if (reg_wr && reg_addr == SGAN_OFF_INT_CLR)
      int_stat_reg <= (int_stat_reg & ~reg_wdata[SGAN_INT_BITS-1:0]) | int_evt;
    else int_stat_reg <= int_stat_reg | int_evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) int_en_reg <= '0;
    else if (reg_wr && reg_addr == SGAN_OFF_INT_EN) int_en_reg <= reg_wdata[SGAN_INT_BITS-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= |(int_stat_reg & int_en_reg);
  end

  // read mux; reserved bits are zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      SGAN_OFF_CONTROL: begin
        rdata_next[SGAN_CTL_MASTER] = master_reg;
        rdata_next[SGAN_CTL_NP_LOADED] = np_loaded_reg;
      end
      SGAN_OFF_STATUS: rdata_next[5:0] = {1'b0, lock_reg, page_rx_reg && lock_reg, an_done_reg,
                                         an_error_in && lock_reg, link_up_in && lock_reg};
      SGAN_OFF_ADV: rdata_next[15:0] = adv_reg;
      SGAN_OFF_NP_TX: rdata_next[15:0] = np_tx_reg;
      SGAN_OFF_LP_ADV: rdata_next[15:0] = lp_adv_reg;
      SGAN_OFF_NP_RX: rdata_next[15:0] = np_rx_reg;
      SGAN_OFF_DIAG_CTL: rdata_next[6:0] = {src_reg, 2'b00, cap_reg};
      SGAN_OFF_DIAG_STS: rdata_next[15:0] = diag_reg;
      SGAN_OFF_INT_STAT: rdata_next[SGAN_INT_BITS-1:0] = int_stat_reg;
      SGAN_OFF_INT_EN: rdata_next[SGAN_INT_BITS-1:0] = int_en_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= rdata_next;
    else reg_rdata <= '0;
  end

  // assertions
  sequence s_flush_write;
    reg_wr && reg_addr == SGAN_OFF_DIAG_CLR && reg_wdata[SGAN_DIAG_CLR_BIT];
  endsequence

  a_flush_clears_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_flush_write |-> ##[3:7] flush_pulse ##1 (diag_reg == 16'h0000)) else $error("flush did not clear");
  a_flush_not_instant: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_flush_write |-> !flush_pulse [*3]) else $error("flush too fast");
  a_mac_link_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mac_side |=> adv_reg[SGAN_ADV_LINK] == $past(link_up_in)) else $error("link bit wrong");
  a_mac_duplex_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 !mac_side |-> adv_reg[SGAN_ADV_DUPLEX] == 1'b0 || $past(mac_side)) else $error("phy duplex not zero");
  a_mac_speed_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mac_side |=> adv_reg[SGAN_ADV_SPD_HI:SGAN_ADV_SPD_LO] == $past(speed_in)) else $error("speed bits wrong");
  a_np_tx_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == SGAN_OFF_NP_TX |=> np_tx_reg == $past(reg_wdata[15:0])) else $error("np tx lost");
  a_page_gated_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    page_valid && !lock_reg |=> $stable(lp_adv_reg)) else $error("page taken without lock");
  a_partner_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    page_evt |=> lp_adv_reg == $past(page_word)) else $error("partner word not captured");
  a_np_rx_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !np_evt |=> $stable(np_rx_reg)) else $error("next page changed without page");
  a_np_loaded_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    np_evt && np_loaded_reg |=> !np_loaded_reg) else $error("np loaded not cleared");
  a_page_flag_late: assert property (@(posedge sys_clk) disable iff (!rst_n)
    np_evt |=> !np_loaded_reg ##1 page_rx_reg) else $error("page flag not set after next page");
  a_master_resolve: assert property (@(posedge sys_clk) disable iff (!rst_n)
    master_reg |=> res_duplex == $past(adv_reg[SGAN_ADV_DUPLEX])) else $error("master resolve wrong");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd |=> reg_rdata[31:16] == 16'h0000) else $error("reserved bits set");
  a_source_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    src_reg == SGAN_SRC_SYNC && !flush_pulse |=> diag_reg == $past(diag_sync_in)) else $error("sync route wrong");
endmodule

// ### include/sgan_pkg.sv
package sgan_pkg;
  // register byte offsets
  localparam logic [7:0] SGAN_OFF_CONTROL = 8'h10;
  localparam logic [7:0] SGAN_OFF_STATUS = 8'h14;
  localparam logic [7:0] SGAN_OFF_ADV = 8'h18;
  localparam logic [7:0] SGAN_OFF_NP_TX = 8'h1C;
  localparam logic [7:0] SGAN_OFF_LP_ADV = 8'h20;
  localparam logic [7:0] SGAN_OFF_NP_RX = 8'h24;
  localparam logic [7:0] SGAN_OFF_DIAG_CLR = 8'h40;
  localparam logic [7:0] SGAN_OFF_DIAG_CTL = 8'h44;
  localparam logic [7:0] SGAN_OFF_DIAG_STS = 8'h48;
  localparam logic [7:0] SGAN_OFF_INT_STAT = 8'h50;
  localparam logic [7:0] SGAN_OFF_INT_CLR = 8'h54;
  localparam logic [7:0] SGAN_OFF_INT_EN = 8'h58;
  // control fields
  localparam int SGAN_CTL_NP_LOADED = 3;
  localparam int SGAN_CTL_MASTER = 5;
  // ability word fields
  localparam int SGAN_ADV_LINK = 15;
  localparam int SGAN_ADV_DUPLEX = 12;
  localparam int SGAN_ADV_SPD_HI = 11;
  localparam int SGAN_ADV_SPD_LO = 10;
  localparam logic [15:0] SGAN_PHY_ADV = 16'h4001;
  localparam logic [1:0] SGAN_SPD_1000 = 2'h2;
  // diagnostic control fields
  localparam int SGAN_DIAG_SRC_HI = 6;
  localparam int SGAN_DIAG_SRC_LO = 4;
  localparam int SGAN_DIAG_CLR_BIT = 0;
  localparam logic [6:0] SGAN_DIAG_CTL_RST = 7'h11;
  localparam int SGAN_FLUSH_SYNC = 2;
  // interrupt bits
  localparam int SGAN_INT_PAGE = 0;
  localparam int SGAN_INT_DONE = 1;
  localparam int SGAN_INT_ERR = 2;
  localparam int SGAN_INT_BITS = 3;
  typedef enum logic [2:0] {
    SGAN_SRC_RSVD = 3'h0, SGAN_SRC_HOLD = 3'h1, SGAN_SRC_SYNC = 3'h2, SGAN_SRC_AN = 3'h3,
    SGAN_SRC_ORDERED_SET_TRANSMITTER = 3'h4, SGAN_SRC_CODE_GROUP_TRANSMITTER = 3'h5, SGAN_SRC_RXLO = 3'h6, SGAN_SRC_RXHI = 3'h7
  } sgan_src_type;
  typedef enum logic [1:0] {
    SGAN_CAP_OFF = 2'h0, SGAN_CAP_LEVEL = 2'h1, SGAN_CAP_RISE = 2'h2, SGAN_CAP_FALL = 2'h3
  } sgan_cap_type;
  typedef enum logic [1:0] {
    SGAN_FL_IDLE = 2'h0, SGAN_FL_SYNC = 2'h1, SGAN_FL_CLEAR = 2'h3
  } sgan_flush_type;
endpackage

// ### hw/sgan_hold_capture.sv
`timescale 1ns/1ps
module sgan_hold_capture import sgan_pkg::*; #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] capture_mode,
  input wire logic clear,
  // signals
  input wire logic [WIDTH-1:0] hold_in,
  output logic [WIDTH-1:0] hold_out
);
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] latch_reg;

  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("sgan_hold_capture: WIDTH must be 1..16");
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) prev_reg <= '0;
    else prev_reg <= hold_in;
  end

  // edges are sticky; a new edge beats the clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic edge_seen;
      assign edge_seen = (capture_mode == SGAN_CAP_RISE) ? (hold_in[i] & ~prev_reg[i]) :
                         (capture_mode == SGAN_CAP_FALL) ? (~hold_in[i] & prev_reg[i]) : 1'b0;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) latch_reg[i] <= 1'b0;
        else if (edge_seen) latch_reg[i] <= 1'b1;
        else if (clear) latch_reg[i] <= 1'b0;
      end
      assign hold_out[i] = (capture_mode == SGAN_CAP_LEVEL) ? hold_in[i] :
                           (capture_mode == SGAN_CAP_OFF) ? 1'b0 : latch_reg[i];
    end
  endgenerate

  a_edge_latched: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode == SGAN_CAP_RISE && hold_in[0] && !prev_reg[0]) ##1 (capture_mode == SGAN_CAP_RISE)
      |-> latch_reg[0]) else $error("rising edge not latched");
endmodule

// ### verification/sgan_partner.sv
`timescale 1ns/1ps
module sgan_partner (
  // clock
  input wire logic sys_clk,
  // pages toward the block
  output logic page_valid,
  output logic [15:0] page_word,
  output logic np_valid,
  output logic [15:0] np_word
);
  initial begin
    page_valid = 1'h0;
    np_valid = 1'h0;
    page_word = 16'h0000;
    np_word = 16'h0000;
  end
  // one-cycle page; lines then show the inverse so a stale word never matches
  task automatic send(input logic np, input logic [15:0] w);
    @(posedge sys_clk);
    if (np) begin
      np_valid <= 1'h1;
      np_word <= w;
    end else begin
      page_valid <= 1'h1;
      page_word <= w;
    end
    @(posedge sys_clk);
    np_valid <= 1'h0;
    page_valid <= 1'h0;
    np_word <= ~w;
    page_word <= ~w;
  endtask
endmodule

// ### verification/sgan_regs_test.sv
`timescale 1ns/1ps
module sgan_regs_test import sgan_pkg::*; ;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic mac_side = 1'h0, sgmii_mode = 1'h0, lock_in = 1'h0, link_up_in = 1'h0, full_duplex_in = 1'h0;
  logic [1:0] speed_in = 2'h0;
  logic an_complete_in = 1'h0, an_error_in = 1'h0;
  logic page_valid, np_valid, np_loaded_out, res_duplex, irq;
  logic [15:0] page_word, np_word, adv_word_out, np_tx_out;
  logic [1:0] res_speed;
  logic [15:0] diag_hold_in = 16'h0;
  logic [31:0] diag_rx_in = 32'h17071606;
  logic [15:0] e;
  logic [2:0] sv;
  logic [31:0] d;
  logic [31:0] q;
  int n_mismatch = 0;
  int total_checks = 0;

  always #20 sys_clk = ~sys_clk;

  sgan_partner i_partner (.sys_clk(sys_clk), .page_valid(page_valid), .page_word(page_word),
    .np_valid(np_valid), .np_word(np_word));

  sgan_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mac_side(mac_side),
    .sgmii_mode(sgmii_mode), .lock_in(lock_in), .link_up_in(link_up_in),
    .full_duplex_in(full_duplex_in), .speed_in(speed_in), .an_complete_in(an_complete_in),
    .an_error_in(an_error_in), .page_valid(page_valid), .page_word(page_word),
    .np_valid(np_valid), .np_word(np_word), .adv_word_out(adv_word_out), .np_tx_out(np_tx_out),
    .np_loaded_out(np_loaded_out), .res_speed(res_speed), .res_duplex(res_duplex),
    .diag_hold_in(diag_hold_in), .diag_sync_in(16'h1202), .diag_an_in(16'h1303),
    .diag_ordered_set_transmitter_in(16'h1404), .diag_code_group_transmitter_in(16'h1505), .diag_rx_in(diag_rx_in), .irq(irq));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // read data is registered, so it is taken just after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] v;
    rd(a, v);
    chk(n, x, v);
  endtask

  initial begin
    cyc(20000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    cyc(10);
    rst_n <= 1'h1;
    cyc(2);
    #1;
    chk("adv_out", 32'h4001, {16'h0, adv_word_out});
    rc(SGAN_OFF_ADV, 32'h4001, "adv");
    rc(SGAN_OFF_DIAG_CTL, 32'h11, "dctl");
    rc(SGAN_OFF_LP_ADV, 32'h0, "lp");
    rc(SGAN_OFF_NP_RX, 32'h0, "nprx");
    mac_side <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      speed_in <= i[1:0];
      link_up_in <= i[0];
      full_duplex_in <= ~i[0];
      cyc(3);
      d = {16'h0, i[0], 2'h0, ~i[0], i[1:0], 10'h0};
      rd(SGAN_OFF_ADV, q);
      chk("adv_mac", d, q & 32'hFFFF9C00);
      chk("adv_out_mac", d, {16'h0, adv_word_out & 16'h9C00});
    end
    wr(SGAN_OFF_NP_TX, 32'hFFFFA5C3);
    rc(SGAN_OFF_NP_TX, 32'h0000A5C3, "nptx");
    cyc(1);
    #1;
    chk("np_tx_out", 32'hA5C3, {16'h0, np_tx_out});
    wr(8'h7C, 32'hFFFFFFFF);
    rc(8'h7C, 32'h0, "unmapped");
    rc(SGAN_OFF_DIAG_CLR, 32'h0, "dclr");
    i_partner.send(1'h0, 16'h1111);
    cyc(2);
    rc(SGAN_OFF_LP_ADV, 32'h0, "lp_unlocked");
    rc(SGAN_OFF_STATUS, 32'h0, "sts_unlocked");
    lock_in <= 1'h1;
    cyc(4);
    i_partner.send(1'h0, 16'h9801);
    cyc(2);
    rc(SGAN_OFF_LP_ADV, 32'h9801, "lp");
    cyc(20);
    rc(SGAN_OFF_LP_ADV, 32'h9801, "lp_hold");
    rc(SGAN_OFF_STATUS, 32'h10, "sts_lock");
    wr(SGAN_OFF_CONTROL, 32'h8);
    rc(SGAN_OFF_CONTROL, 32'h8, "ctl_np");
    chk("np_loaded_out", 32'h1, {31'h0, np_loaded_out});
    i_partner.send(1'h1, 16'h1234);
    cyc(2);
    rc(SGAN_OFF_NP_RX, 32'h1234, "nprx");
    rc(SGAN_OFF_CONTROL, 32'h0, "ctl_np_clr");
    chk("np_loaded_out_clr", 32'h0, {31'h0, np_loaded_out});
    rc(SGAN_OFF_STATUS, 32'h18, "sts_np1");
    i_partner.send(1'h1, 16'h5678);
    cyc(2);
    rc(SGAN_OFF_NP_RX, 32'h5678, "nprx2");
    rc(SGAN_OFF_STATUS, 32'h18, "sts_np2");
    wr(SGAN_OFF_CONTROL, 32'h8);
    rc(SGAN_OFF_STATUS, 32'h10, "sts_np_ack");
    sgmii_mode <= 1'h1;
    i_partner.send(1'h1, 16'h4321);
    cyc(2);
    rc(SGAN_OFF_NP_RX, 32'h5678, "nprx_sgmii");
    rc(SGAN_OFF_INT_STAT, 32'h1, "int_np");
    wr(SGAN_OFF_INT_CLR, 32'h7);
    wr(SGAN_OFF_INT_EN, 32'h2);
    an_complete_in <= 1'h1;
    cyc(4);
    #1;
    chk("irq_done", 32'h1, {31'h0, irq});
    rc(SGAN_OFF_INT_STAT, 32'h2, "int_done");
    wr(SGAN_OFF_INT_EN, 32'h0);
    cyc(2);
    #1;
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(SGAN_OFF_INT_CLR, 32'h2);
    rc(SGAN_OFF_INT_STAT, 32'h0, "int_clr");
    an_error_in <= 1'h1;
    wr(SGAN_OFF_INT_EN, 32'h4);
    wr(SGAN_OFF_INT_CLR, 32'h4);
    cyc(2);
    #1;
    chk("irq_err", 32'h1, {31'h0, irq});
    rc(SGAN_OFF_INT_STAT, 32'h4, "int_err_lvl");
    an_error_in <= 1'h0;
    wr(SGAN_OFF_INT_CLR, 32'h4);
    cyc(2);
    #1;
    chk("irq_off", 32'h0, {31'h0, irq});
    chk("res_partner", 32'h6, {29'h0, res_duplex, res_speed});
    speed_in <= 2'h1;
    full_duplex_in <= 1'h0;
    wr(SGAN_OFF_CONTROL, 32'h20);
    cyc(4);
    #1;
    chk("res_master", 32'h1, {29'h0, res_duplex, res_speed});
    for (int i = 0; i < 8; i++) begin
      if (i == 1) continue;
      sv = i[2:0];
      e = (i == 0) ? 16'h0 : {4'h1, 1'h0, sv, 5'h0, sv};
      wr(SGAN_OFF_DIAG_CTL, {25'h1FFFFFF, sv, 4'hD});
      cyc(3);
      rc(SGAN_OFF_DIAG_CTL, {25'h0, sv, 4'h1}, "dctl_rb");
      rc(SGAN_OFF_DIAG_STS, {16'h0, e}, "dsts_src");
    end
    diag_hold_in <= 16'h00F0;
    wr(SGAN_OFF_DIAG_CTL, 32'h11);
    cyc(5);
    rc(SGAN_OFF_DIAG_STS, 32'hF0, "hold_level");
    wr(SGAN_OFF_DIAG_CLR, 32'h1);
    cyc(12);
    rc(SGAN_OFF_DIAG_STS, 32'hF0, "hold_persist");
    wr(SGAN_OFF_DIAG_CTL, 32'h10);
    cyc(5);
    rc(SGAN_OFF_DIAG_STS, 32'h0, "hold_off");
    // idle level first, then one edge and its return
    for (int m = 2; m < 4; m++) begin
      diag_hold_in <= {15'h0, m[0]};
      wr(SGAN_OFF_DIAG_CTL, {28'h1, m[3:0]});
      wr(SGAN_OFF_DIAG_CLR, 32'h1);
      cyc(12);
      rc(SGAN_OFF_DIAG_STS, 32'h0, "edge_idle");
      diag_hold_in <= {15'h0, ~m[0]};
      cyc(6);
      diag_hold_in <= {15'h0, m[0]};
      cyc(6);
      rc(SGAN_OFF_DIAG_STS, 32'h1, "edge_sticky");
      wr(SGAN_OFF_DIAG_CLR, 32'h1);
      rc(SGAN_OFF_DIAG_STS, 32'h1, "flush_early");
      cyc(10);
      rc(SGAN_OFF_DIAG_STS, 32'h0, "flush_done");
    end
    report_and_stop();
  end
endmodule
